// *** cpc_pkg.sv ***
// constants and carrier types for the clock and power control registers
// Operation
// RL1: clocking code 000 selects standard full-duplex and half-duplex interface clocking
// RL2: clocking code 001 selects the optional full-duplex timing variant
// RL3: clocking code 011 selects the optional wide half-duplex timing variant
// RL4: clocking code 101 selects the optional narrow half-duplex timing variant
// RL5: clocking field resets to 000; code 111 selects clone mode
// RL6: software never writes clocking codes 010, 100 or 110
// RL7: second-port clock-out enable makes the second port drive an output clock
// RL8: in full-duplex that enable also inverts the second-port clock
// RL9: third-port invert bit flips the polarity of the third-port clock
// RL10: transmit analog code 100 disables only channel A output
// RL11: transmit analog code 010 disables only channel B output
// RL12: a third code disables both outputs and part of the support circuitry
// RL13: converter bias current stays on in every transmit power-down setting
// RL14: transmit digital power-down resets low; when set clocks stop, outputs hold
// RL15: receive digital power-down bit powers down the receive digital section
// RL16: digital blocks unused by the configuration power down automatically
// RL17: multiplier power-down bit stops the multiplier and bypasses it
// RL18: when bypassed, the reference clock equals the fastest on-chip clock
// RL19: disconnect bit removes multiplier output; an enabled multiplier keeps locking
// RL20: each receive converter powers down on its own bit
// RL21: receive power-down covers references, input buffer, analog and channel digital
package cpc_pkg;
  localparam logic [4:0] ADDR_CLK_SELECT    = 5'h01;
  localparam logic [4:0] ADDR_TX_POWER      = 5'h02;
  localparam logic [4:0] ADDR_RX_SHUTDOWN   = 5'h03;
  localparam logic [4:0] ADDR_RX_B_SHUTDOWN = 5'h04;
  localparam int CLK_SEL_HI   = 7;
  localparam int CLK_SEL_LO   = 5;
  localparam int PORT2_EN_BIT = 2;
  localparam int PORT3_INV_BIT = 1;
  localparam int TX_ANA_HI    = 7;
  localparam int TX_ANA_LO    = 5;
  localparam int TX_DIG_BIT   = 4;
  localparam int RX_DIG_BIT   = 3;
  localparam int MUL_PD_BIT   = 2;
  localparam int MUL_DISC_BIT = 1;
  localparam int RX_PD_BIT    = 7;
  localparam logic [2:0] CLK_SEL_RESET = 3'h0;
  localparam logic [2:0] TX_ANA_RESET  = 3'h0;
  localparam logic       BIT_RESET     = 1'b0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [2:0] TX_PD_A    = 3'h4;
  localparam logic [2:0] TX_PD_B    = 3'h2;
  localparam logic [2:0] TX_PD_BOTH = 3'h6;
  localparam logic [4:0] SER_HDR_LAST   = 5'h07;
  localparam logic [4:0] SER_FRAME_LAST = 5'h0f;
  localparam logic [4:0] SER_FRAME_END  = 5'h10;
  localparam int SER_RW_BIT = 7;
  localparam int TX_W = 10;
  typedef enum logic [2:0] {
    CLK_STANDARD  = 3'b000,
    CLK_FULL_ALT  = 3'b001,
    CLK_RSV2      = 3'b010,
    CLK_WIDE_ALT  = 3'b011,
    CLK_RSV4      = 3'b100,
    CLK_NARROW_ALT = 3'b101,
    CLK_RSV6      = 3'b110,
    CLK_CLONE     = 3'b111
  } clkMode_e;
  typedef struct packed {
    logic sclk;
    logic csN;
    logic sdi;
  } serialPins_s;
  localparam serialPins_s PINS_IDLE = '{sclk: 1'b0, csN: 1'b1, sdi: 1'b0};
  typedef struct packed {
    logic       stb;
    logic [4:0] addr;
    logic [7:0] data;
  } cfgWrite_s;
  typedef struct packed {
    logic standard;
    logic fullAlt;
    logic wideAlt;
    logic narrowAlt;
    logic clone;
    logic reserved;
    logic port2ClkOe;
    logic port2ClkInvert;
    logic port3ClkInvert;
  } ifaceClocking_s;
  typedef struct packed {
    logic chanAOff;
    logic chanBOff;
    logic supportOff;
    logic digClkEn;
  } txPower_s;
  typedef struct packed {
    logic mulRun;
    logic mulBypass;
    logic mulOutSelected;
  } clockGen_s;
  typedef struct packed {
    logic analogOff;
    logic refOff;
    logic bufferOff;
    logic digitalOff;
  } rxChannel_s;
  typedef struct packed {
    logic [TX_W-1:0] a;
    logic [TX_W-1:0] b;
  } txPair_s;
endpackage : cpc_pkg

// *** pin_sync.sv ***
// two-stage synchroniser for the serial configuration pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire cpc_pkg::serialPins_s pinsIn,
  output cpc_pkg::serialPins_s      pinsOut
);
  import cpc_pkg::*;
  typedef struct packed {
    serialPins_s meta;
    serialPins_s stable;
  } syncState_s;
  syncState_s st_r, st_nxt;
  // the first stage feeds only the second
  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = pinsIn;
    st_nxt.stable = st_r.meta;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{meta: PINS_IDLE, stable: PINS_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pinsOut = st_r.stable;
endmodule : pin_sync
`default_nettype wire

// *** serial_config_port.sv ***
// serial configuration port: 8-bit header then 8-bit data, msb first
`timescale 1ns/100ps
`default_nettype none
module serial_config_port (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire cpc_pkg::serialPins_s pins,
  input  wire logic [7:0]           rdData,
  output logic [4:0]                rdAddr,
  output cpc_pkg::cfgWrite_s        cfgWr,
  output logic                      sdoOut,
  output logic                      sdoOe
);
  import cpc_pkg::*;
  typedef struct packed {
    logic       sclkPrev;
    logic [4:0] bitCnt;
    logic [7:0] inShift;
    logic       isRead;
    logic [4:0] addr;
    logic       loadPend;
    logic [7:0] outShift;
    logic       sdo;
    logic       oe;
    cfgWrite_s  wr;
  } serState_s;
  serState_s  st_r, st_nxt;
  logic       sclkRise;
  logic       sclkFall;
  logic [7:0] shifted;
  // pins are sampled slowly, so sclk must run well below clk/4
  always_comb begin
    sclkRise        = pins.sclk & ~st_r.sclkPrev;
    sclkFall        = ~pins.sclk & st_r.sclkPrev;
    shifted         = {st_r.inShift[6:0], pins.sdi};
    st_nxt          = st_r;
    st_nxt.sclkPrev = pins.sclk;
    st_nxt.wr.stb   = 1'b0;
    st_nxt.loadPend = 1'b0;
    if (st_r.loadPend) begin
      st_nxt.outShift = rdData;
    end
    if (pins.csN) begin
      st_nxt.bitCnt = 5'h00;
      st_nxt.isRead = 1'b0;
      st_nxt.oe     = 1'b0;
    end else if (sclkRise && st_r.bitCnt != SER_FRAME_END) begin
      st_nxt.inShift = shifted;
      st_nxt.bitCnt  = st_r.bitCnt + 5'h01;
      if (st_r.bitCnt == SER_HDR_LAST) begin
        st_nxt.isRead   = shifted[SER_RW_BIT];
        st_nxt.addr     = shifted[4:0];
        st_nxt.loadPend = shifted[SER_RW_BIT];
      end
      if (st_r.bitCnt == SER_FRAME_LAST && !st_r.isRead) begin
        st_nxt.wr.stb  = 1'b1;
        st_nxt.wr.addr = st_r.addr;
        st_nxt.wr.data = shifted;
      end
    end else if (sclkFall && st_r.isRead && st_r.bitCnt > SER_HDR_LAST
                 && st_r.bitCnt != SER_FRAME_END) begin
      st_nxt.sdo      = st_r.outShift[7];
      st_nxt.outShift = {st_r.outShift[6:0], 1'b0};
      st_nxt.oe       = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rdAddr = st_r.addr;
  assign cfgWr  = st_r.wr;
  assign sdoOut = st_r.sdo;
  assign sdoOe  = st_r.oe;
endmodule : serial_config_port
`default_nettype wire

// *** clock_and_power_control_regs.sv ***
// clock mode, port clock and power-down configuration registers
`timescale 1ns/100ps
`default_nettype none
module clock_and_power_control_regs (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire cpc_pkg::serialPins_s serPins,
  output logic                      sdoOut,
  output logic                      sdoOe,
  input  wire logic                 fullDuplex,
  input  wire logic                 txPathUsed,
  input  wire logic                 rxPathUsed,
  input  wire cpc_pkg::txPair_s     txDataIn,
  input  wire logic                 txDataValid,
  output cpc_pkg::txPair_s          txDataOut,
  output cpc_pkg::ifaceClocking_s   ifaceCtl,
  output cpc_pkg::txPower_s         txCtl,
  output logic                      txBiasOn,
  output cpc_pkg::clockGen_s        clkGenCtl,
  output logic                      rxDigEnable,
  output cpc_pkg::rxChannel_s       rxChanA,
  output cpc_pkg::rxChannel_s       rxChanB,
  output logic                      rxBandgapOn
);
  import cpc_pkg::*;

  typedef struct packed {
    clkMode_e   clkSel;
    logic       port2En;
    logic       port3Inv;
    logic [2:0] txAna;
    logic       txDigPd;
    logic       rxDigPd;
    logic       mulPd;
    logic       mulDisc;
    logic       rxAPd;
    logic       rxBPd;
    txPair_s    txHold;
  } ctlState_s;

  ctlState_s          st_r, st_nxt;
  serialPins_s        pinsSync;
  cfgWrite_s          cfgWr;
  logic [4:0]         rdAddr;
  logic [7:0]         rdData;
  txPower_s           txDecoded;

  pin_sync u_pin_sync (
    .clk     (clk),
    .rst     (rst),
    .pinsIn  (serPins),
    .pinsOut (pinsSync)
  );

  serial_config_port u_serial (
    .clk    (clk),
    .rst    (rst),
    .pins   (pinsSync),
    .rdData (rdData),
    .rdAddr (rdAddr),
    .cfgWr  (cfgWr),
    .sdoOut (sdoOut),
    .sdoOe  (sdoOe)
  );

  // interface clocking decode; reserved codes fall to standard timing
  function automatic ifaceClocking_s decodeClocking(
    input clkMode_e sel,
    input logic     p2En,
    input logic     p3Inv,
    input logic     duplex
  );
    ifaceClocking_s c;
    c = '0;
    case (sel)
      CLK_STANDARD: begin
        c.standard = 1'b1; // [RL1]
      end
      CLK_FULL_ALT: begin
        c.fullAlt = 1'b1; // [RL2]
      end
      CLK_WIDE_ALT: begin
        c.wideAlt = 1'b1; // [RL3]
      end
      CLK_NARROW_ALT: begin
        c.narrowAlt = 1'b1; // [RL4]
      end
      CLK_CLONE: begin
        c.clone = 1'b1; // [RL5]
      end
      default: begin
        // software keeps off these codes; flag them and run standard timing
        c.reserved = 1'b1; // [RL6]
        c.standard = 1'b1;
      end
    endcase
    c.port2ClkOe     = p2En; // [RL7]
    c.port2ClkInvert = p2En & duplex; // [RL8]
    c.port3ClkInvert = p3Inv; // [RL9]
    return c;
  endfunction : decodeClocking

  // transmit analog and digital power decode
  function automatic txPower_s decodeTxPower(
    input logic [2:0] code,
    input logic       digPd,
    input logic       used
  );
    txPower_s t;
    t = '0;
    if (code == TX_PD_A) begin
      t.chanAOff = 1'b1; // [RL10]
    end else if (code == TX_PD_B) begin
      t.chanBOff = 1'b1; // [RL11]
    end else if (code == TX_PD_BOTH) begin
      t.chanAOff   = 1'b1; // [RL12]
      t.chanBOff   = 1'b1;
      t.supportOff = 1'b1;
    end
    t.digClkEn = ~digPd & used; // [RL14] [RL16]
    return t;
  endfunction : decodeTxPower

  // one receive channel: everything but the bandgap goes down together
  function automatic rxChannel_s decodeRxChannel(
    input logic pd
  );
    rxChannel_s r;
    r.analogOff  = pd; // [RL21]
    r.refOff     = pd;
    r.bufferOff  = pd;
    r.digitalOff = pd;
    return r;
  endfunction : decodeRxChannel

  // register readback; reserved bits read as zero
  function automatic logic [7:0] readReg(
    input logic [4:0] addr,
    input ctlState_s  s
  );
    logic [7:0] d;
    d = READ_UNMAPPED;
    if (addr == ADDR_CLK_SELECT) begin
      d[CLK_SEL_HI:CLK_SEL_LO] = s.clkSel;
      d[PORT2_EN_BIT]          = s.port2En;
      d[PORT3_INV_BIT]         = s.port3Inv;
    end else if (addr == ADDR_TX_POWER) begin
      d[TX_ANA_HI:TX_ANA_LO] = s.txAna;
      d[TX_DIG_BIT]          = s.txDigPd;
      d[RX_DIG_BIT]          = s.rxDigPd;
      d[MUL_PD_BIT]          = s.mulPd;
      d[MUL_DISC_BIT]        = s.mulDisc;
    end else if (addr == ADDR_RX_SHUTDOWN) begin
      d[RX_PD_BIT] = s.rxAPd;
    end else if (addr == ADDR_RX_B_SHUTDOWN) begin
      d[RX_PD_BIT] = s.rxBPd;
    end
    return d;
  endfunction : readReg

  always_comb begin
    st_nxt    = st_r;
    txDecoded = decodeTxPower(st_r.txAna, st_r.txDigPd, txPathUsed);
    // writes to unmapped addresses are dropped
    if (cfgWr.stb) begin
      if (cfgWr.addr == ADDR_CLK_SELECT) begin
        st_nxt.clkSel   = clkMode_e'(cfgWr.data[CLK_SEL_HI:CLK_SEL_LO]);
        st_nxt.port2En  = cfgWr.data[PORT2_EN_BIT];
        st_nxt.port3Inv = cfgWr.data[PORT3_INV_BIT];
      end else if (cfgWr.addr == ADDR_TX_POWER) begin
        st_nxt.txAna   = cfgWr.data[TX_ANA_HI:TX_ANA_LO];
        st_nxt.txDigPd = cfgWr.data[TX_DIG_BIT];
        st_nxt.rxDigPd = cfgWr.data[RX_DIG_BIT];
        st_nxt.mulPd   = cfgWr.data[MUL_PD_BIT];
        st_nxt.mulDisc = cfgWr.data[MUL_DISC_BIT];
      end else if (cfgWr.addr == ADDR_RX_SHUTDOWN) begin
        st_nxt.rxAPd = cfgWr.data[RX_PD_BIT]; // [RL20]
      end else if (cfgWr.addr == ADDR_RX_B_SHUTDOWN) begin
        st_nxt.rxBPd = cfgWr.data[RX_PD_BIT]; // [RL20]
      end
    end
    // gated transmit path: a stopped path keeps its last sample on the pins
    if (txDataValid && txDecoded.digClkEn) begin
      st_nxt.txHold = txDataIn; // [RL14]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.clkSel   <= clkMode_e'(CLK_SEL_RESET); // [RL5]
      st_r.port2En  <= BIT_RESET;
      st_r.port3Inv <= BIT_RESET;
      st_r.txAna    <= TX_ANA_RESET;
      st_r.txDigPd  <= BIT_RESET; // [RL14]
      st_r.rxDigPd  <= BIT_RESET;
      st_r.mulPd    <= BIT_RESET;
      st_r.mulDisc  <= BIT_RESET;
      st_r.rxAPd    <= BIT_RESET;
      st_r.rxBPd    <= BIT_RESET;
      st_r.txHold   <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData    = readReg(rdAddr, st_r);
  assign txDataOut = st_r.txHold;
  assign ifaceCtl  = decodeClocking(st_r.clkSel, st_r.port2En, st_r.port3Inv, fullDuplex);
  assign txCtl     = txDecoded;
  // bias stays up in every setting so outputs return within a few cycles
  assign txBiasOn  = 1'b1; // [RL13]

  // a stopped multiplier is bypassed, so the reference must already run at
  // the fastest on-chip rate [RL18]
  assign clkGenCtl.mulRun         = ~st_r.mulPd; // [RL17] [RL19]
  assign clkGenCtl.mulBypass      = st_r.mulPd; // [RL17]
  assign clkGenCtl.mulOutSelected = ~st_r.mulPd & ~st_r.mulDisc; // [RL19]

  assign rxDigEnable = ~st_r.rxDigPd & rxPathUsed; // [RL15] [RL16]
  assign rxChanA     = decodeRxChannel(st_r.rxAPd); // [RL20]
  assign rxChanB     = decodeRxChannel(st_r.rxBPd); // [RL20]
  assign rxBandgapOn = 1'b1;
endmodule : clock_and_power_control_regs
`default_nettype wire

// *** cpc_assertions.sv ***
// concurrent checks on the clock and power control register block ports
`timescale 1ns/100ps
`default_nettype none
module cpc_checker (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    fullDuplex,
  input wire logic                    txPathUsed,
  input wire logic                    rxPathUsed,
  input wire cpc_pkg::txPair_s        txDataIn,
  input wire logic                    txDataValid,
  input wire cpc_pkg::txPair_s        txDataOut,
  input wire cpc_pkg::ifaceClocking_s ifaceCtl,
  input wire cpc_pkg::txPower_s       txCtl,
  input wire logic                    txBiasOn,
  input wire cpc_pkg::clockGen_s      clkGenCtl,
  input wire logic                    rxDigEnable,
  input wire cpc_pkg::rxChannel_s     rxChanA,
  input wire cpc_pkg::rxChannel_s     rxChanB
);
  import cpc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_capture;
    txDataValid && txCtl.digClkEn;
  endsequence
  sequence s_frozen;
    !txCtl.digClkEn;
  endsequence
  property p_capture;
    s_capture |=> (txDataOut == $past(txDataIn));
  endproperty
  a_capture: assert property (p_capture)
    else $error("transmit sample not taken");
  // a stopped digital clock must freeze the outputs, whatever the strobe does
  property p_hold;
    s_frozen |=> $stable(txDataOut);
  endproperty
  a_hold: assert property (p_hold)
    else $error("transmit outputs moved while stopped");
  property p_bias;
    txBiasOn;
  endproperty
  a_bias: assert property (p_bias)
    else $error("converter bias switched off");
  property p_mode;
    $onehot({ifaceCtl.standard, ifaceCtl.fullAlt, ifaceCtl.wideAlt,
             ifaceCtl.narrowAlt, ifaceCtl.clone});
  endproperty
  a_mode: assert property (p_mode)
    else $error("clocking mode not one-hot");
  property p_port2;
    ifaceCtl.port2ClkInvert == (ifaceCtl.port2ClkOe && fullDuplex);
  endproperty
  a_port2: assert property (p_port2)
    else $error("second port invert wrong");
  property p_txUsed;
    !txPathUsed |-> !txCtl.digClkEn;
  endproperty
  a_txUsed: assert property (p_txUsed)
    else $error("unused transmit path still clocked");
  property p_rxUsed;
    rxDigEnable |-> rxPathUsed;
  endproperty
  a_rxUsed: assert property (p_rxUsed)
    else $error("unused receive path still enabled");
  property p_bypass;
    clkGenCtl.mulBypass != clkGenCtl.mulRun;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("multiplier bypass and run disagree");
  property p_mulOut;
    clkGenCtl.mulOutSelected |-> clkGenCtl.mulRun;
  endproperty
  a_mulOut: assert property (p_mulOut)
    else $error("stopped multiplier selected");
  property p_support;
    txCtl.supportOff |-> (txCtl.chanAOff && txCtl.chanBOff);
  endproperty
  a_support: assert property (p_support)
    else $error("support off with a channel on");
  property p_rxChan;
    (rxChanA == {4{rxChanA.analogOff}}) && (rxChanB == {4{rxChanB.analogOff}});
  endproperty
  a_rxChan: assert property (p_rxChan)
    else $error("receive channel parts disagree");
endmodule : cpc_checker
bind clock_and_power_control_regs cpc_checker cpc_checker_i (.clk, .rst, .fullDuplex,
  .txPathUsed, .rxPathUsed, .txDataIn, .txDataValid, .txDataOut, .ifaceCtl, .txCtl,
  .txBiasOn, .clkGenCtl, .rxDigEnable, .rxChanA, .rxChanB);
`default_nettype wire

// *** clock_and_power_control_regs_bench.sv ***
// self-checking bench for the clock and power control register block
`timescale 1ns/100ps
`default_nettype none
module clock_and_power_control_regs_bench;
  import cpc_pkg::*;
  logic           clk, rst, fullDuplex, txPathUsed, rxPathUsed, txDataValid;
  logic           sdoOut, sdoOe, txBiasOn, rxDigEnable, rxBandgapOn;
  serialPins_s    serPins;
  txPair_s        txDataIn, txDataOut;
  ifaceClocking_s ifaceCtl;
  txPower_s       txCtl;
  clockGen_s      clkGenCtl;
  rxChannel_s     rxChanA, rxChanB;
  int             err_count = 0;
  int             n_compared = 0;
  logic [7:0]     rdv;
  logic           oeSeen;
  logic [2:0]     code;
  logic [2:0]     legal [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7}; // reserved codes never sent
  clock_and_power_control_regs clock_and_power_control_regs_i (.clk, .rst, .serPins, .sdoOut,
    .sdoOe, .fullDuplex, .txPathUsed, .rxPathUsed, .txDataIn, .txDataValid, .txDataOut,
    .ifaceCtl, .txCtl, .txBiasOn, .clkGenCtl, .rxDigEnable, .rxChanA, .rxChanB, .rxBandgapOn);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // automatic: the watchdog and the tests wait through this task at the same time
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // sclk phases of 6 cycles clear the synchroniser delay; read bits sampled before each rise
  task frame(input logic [7:0] hdr, input logic [7:0] din, input int nbits, output logic [7:0] dout);
    logic [15:0] sh;
    sh = {hdr, din};
    dout = 8'h00;
    serPins.csN = 1'b0;
    tick(6);
    for (int i = 0; i < nbits; i++) begin
      serPins.sdi = sh[15-i];
      serPins.sclk = 1'b0;
      tick(6);
      dout = {dout[6:0], sdoOut};
      oeSeen = sdoOe;
      serPins.sclk = 1'b1;
      tick(6);
    end
    serPins = PINS_IDLE;
    tick(8);
  endtask : frame
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    frame({3'b000, a}, d, 16, x);
  endtask : wr
  task rd(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] x;
    frame({3'b100, a}, 8'h00, 16, x);
    check("readback", 20'(x), 20'(exp));
    check("sdo_oe_driving", 20'(oeSeen), 20'h00001);
    check("sdo_oe_released", 20'(sdoOe), 20'h00000);
  endtask : rd
  task results;
    $display("comparisons %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  initial begin
    tick(30000);
    err_count++;
    $display("ERROR watchdog expected finish seen timeout");
    results;
  end
  initial begin
    serPins = PINS_IDLE;
    fullDuplex = 1'b1;
    txPathUsed = 1'b1;
    rxPathUsed = 1'b1;
    txDataIn = '0;
    txDataValid = 1'b0;
    rst = 1'b1;
    tick(20);
    rst = 1'b0;
    tick(3);
    check("iface", 20'(ifaceCtl), 20'h00100);
    check("clkgen", 20'(clkGenCtl), 20'h00005);
    check("digclk", 20'(txCtl.digClkEn), 20'h00001);
    for (int a = 1; a < 5; a++) rd(5'(a), 8'h00);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      code = legal[i];
      wr(ADDR_CLK_SELECT, {code, 5'b00110});
      rd(ADDR_CLK_SELECT, {code, 5'b00110});
      check("iface", 20'(ifaceCtl), 20'({code == 3'h0, code == 3'h1, code == 3'h3,
        code == 3'h5, code == 3'h7, 4'b0111}));
    end
    fullDuplex = 1'b0;
    tick(1);
    check("port2", 20'(ifaceCtl[2:1]), 20'h00002);
    fullDuplex = 1'b1;
    wr(ADDR_CLK_SELECT, 8'h00);
    check("iface", 20'(ifaceCtl), 20'h00100);
    $display("test clocking done");
    for (int c = 0; c < 8; c++) begin
      code = 3'(c);
      wr(ADDR_TX_POWER, {code, 5'b00000});
      check("txana", 20'(txCtl[3:1]), 20'({code == 3'h4 || code == 3'h6,
        code == 3'h2 || code == 3'h6, code == 3'h6}));
      check("bias", 20'(txBiasOn), 20'h00001);
    end
    $display("test tx analog done");
    txDataIn = 20'h2a5c3;
    txDataValid = 1'b1;
    tick(1);
    txDataValid = 1'b0;
    tick(1);
    check("txdata", txDataOut, 20'h2a5c3);
    // the bench clock stands in for a reference already at the fastest rate
    wr(ADDR_TX_POWER, 8'h1e);
    txDataIn = 20'h0f0f1;
    txDataValid = 1'b1;
    tick(2);
    txDataValid = 1'b0;
    check("txdata", txDataOut, 20'h2a5c3);
    check("rxdig", 20'(rxDigEnable), 20'h00000);
    check("clkgen", 20'(clkGenCtl), 20'h00002);
    wr(ADDR_TX_POWER, 8'h02);
    check("clkgen", 20'(clkGenCtl), 20'h00004);
    wr(ADDR_TX_POWER, 8'h00);
    txPathUsed = 1'b0;
    rxPathUsed = 1'b0;
    tick(1);
    check("digclk", 20'(txCtl.digClkEn), 20'h00000);
    check("rxdig", 20'(rxDigEnable), 20'h00000);
    txPathUsed = 1'b1;
    rxPathUsed = 1'b1;
    tick(1);
    check("rxdig", 20'(rxDigEnable), 20'h00001);
    $display("test power done");
    wr(ADDR_RX_SHUTDOWN, 8'h80);
    check("rxchan", 20'({rxChanA, rxChanB}), 20'h000f0);
    check("bandgap", 20'(rxBandgapOn), 20'h00001);
    wr(ADDR_RX_B_SHUTDOWN, 8'h80);
    rd(ADDR_RX_SHUTDOWN, 8'h80);
    wr(ADDR_RX_SHUTDOWN, 8'h00);
    check("rxchan", 20'({rxChanA, rxChanB}), 20'h0000f);
    $display("test rx done");
    rd(5'h05, 8'h00);
    // a frame cut short must leave the register untouched
    frame({3'b000, ADDR_CLK_SELECT}, 8'he4, 10, rdv);
    check("iface", 20'(ifaceCtl), 20'h00100);
    wr(ADDR_CLK_SELECT, 8'he4);
    check("iface", 20'(ifaceCtl), 20'h00016);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    check("iface", 20'(ifaceCtl), 20'h00100);
    check("clkgen", 20'(clkGenCtl), 20'h00005);
    check("txdata", txDataOut, 20'h00000);
    $display("test refusal done");
    results;
  end
endmodule : clock_and_power_control_regs_bench
`default_nettype wire
